// File: include/apc_pkg.sv
// applicator i/o port control: shared constants, types and state layouts
// assumes a single 125 MHz system clock; all times derive from it
package apc_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_S    = 1_000_000_000 / TICK_PERIOD_NS;

    // supervision times
    localparam int UP_TIMEOUT_S       = 5;
    localparam int DOWN_TIMEOUT_S     = 3;
    localparam int UP_TIMEOUT_TICKS   = UP_TIMEOUT_S * TICKS_PER_S;
    localparam int DOWN_TIMEOUT_TICKS = DOWN_TIMEOUT_S * TICKS_PER_S;

    // strobe half period and input filter lengths, in ticks
    localparam int STROBE_HALF_MS = 250;
    localparam int CMD_DEBOUNCE_MS = 10;
    localparam int SENSOR_DEBOUNCE_MS = 1;

    // counter widths
    localparam int TMR_W  = 13;
    localparam int DIV_W  = 17;
    localparam int SCNT_W = 8;
    localparam int DEB_W  = 4;

    // values after reset
    localparam logic RELAY_RESET = 1'b0;
    localparam logic MECH_RESET  = 1'b0;
    localparam logic FAULT_RESET = 1'b0;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_PRINT  = 5'h02,
        ST_FEED   = 5'h04,
        ST_APPLY  = 5'h08,
        ST_RETURN = 5'h10
    } apc_state_e;

    // port pins, raw and asynchronous
    typedef struct packed {
        logic start_p;
        logic start_n;
        logic stop_p;
        logic stop_n;
        logic pad_up;
        logic pad_down;
        logic reset_btn;
    } apc_pins_s;

    // printer side handshake, same clock
    typedef struct packed {
        logic job_pending;
        logic print_done;
        logic feed_done;
    } apc_ptr_s;

    // mechanism commands
    typedef struct packed {
        logic print;
        logic feed;
        logic apply;
    } apc_mech_s;

    // relay outputs
    typedef struct packed {
        logic up;
        logic down;
        logic fault_relay_out;
    } apc_relay_s;

    typedef struct packed {
        logic              s1;
        logic              s2;
        logic              s3;
        logic              level;
        logic              rise;
        logic [DEB_W-1:0]  cnt;
    } apc_sync_s;

    typedef struct packed {
        logic [DIV_W-1:0]  div;
        logic              tick;
        logic [SCNT_W-1:0] scnt;
        logic              strobe;
    } apc_tick_s;

    typedef struct packed {
        apc_state_e       state;
        logic [TMR_W-1:0] tmr;
        logic             up_err;
        logic             dn_err;
        apc_mech_s        mech;
        apc_relay_s       relay;
    } apc_ctrl_s;

endpackage : apc_pkg

// File: src/apc_sync.sv
// pin input conditioner: three-stage synchroniser, tick-based debounce,
// rising-edge request pulse; expects a one-cycle tick from the divider
`timescale 1ns/1ps
`default_nettype none
module apc_sync #(
    parameter logic [apc_pkg::DEB_W-1:0] DEB_TICKS = 4'h1
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    // time base
    input  wire logic tick_i,
    // raw pin level
    input  wire logic raw_i,
    // conditioned outputs
    output logic      level_o,
    output logic      rise_o
);
    import apc_pkg::*;

    apc_sync_s st_reg;
    apc_sync_s st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.s1   = raw_i;
        st_next.s2   = st_reg.s1;
        st_next.s3   = st_reg.s2;
        st_next.rise = 1'b0;
        // stages two and three must agree before a change is timed
        if (st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.level) begin
            if (tick_i) begin
                if (st_reg.cnt + 4'h1 >= DEB_TICKS) begin
                    st_next.level = st_reg.s3;
                    st_next.rise  = st_reg.s3;
                    st_next.cnt   = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + 4'h1;
                end
            end
        end else begin
            st_next.cnt = '0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level;
    assign rise_o  = st_reg.rise;

    // a rising level change yields one pulse only; a new one needs a release
    rise_single_a: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        rise_o |=> !rise_o)
        else $error("request pulse longer than one cycle");

endmodule : apc_sync
`default_nettype wire

// File: src/apc_tick.sv
// time base: one-cycle millisecond tick and a slow strobe square wave
// assumes the top passes the cycle count of one tick
`timescale 1ns/1ps
`default_nettype none
module apc_tick #(
    parameter int TICK_CYC = apc_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    // outputs
    output logic      tick_o,
    output logic      strobe_o
);
    import apc_pkg::*;

    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(TICK_CYC - 1);
    localparam logic [SCNT_W-1:0] SCNT_LAST = SCNT_W'(STROBE_HALF_MS - 1);

    apc_tick_s st_reg;
    apc_tick_s st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.div == DIV_LAST) begin
            st_next.div  = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 17'h0_0001;
        end
        if (st_reg.tick) begin
            if (st_reg.scnt == SCNT_LAST) begin
                st_next.scnt   = '0;
                st_next.strobe = ~st_reg.strobe;
            end else begin
                st_next.scnt = st_reg.scnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o   = st_reg.tick;
    assign strobe_o = st_reg.strobe;

endmodule : apc_tick
`default_nettype wire

// File: src/apc_ctrl.sv
// applicator i/o port control: start/stop handling, print-feed-apply
// sequencer, pad supervision and relay drive
// assumes raw port pins, printer handshakes on clk_sys_i, relays driven
// directly from the relay outputs
//
// Operation
// - start with a pending job and no latched fault runs print, feed and apply in that order
// - start without a pending job is dropped, nothing queued
// - each further start needs the trigger released and reasserted
// - start is valid when plus line high and minus line low
// - stop aborts everything, retracts the pad and returns to idle
// - stop clears latched errors; they may return if cause persists
// - up relay follows the pad's up position after the one-tick sensor filter
// - pad leaving up during label feed raises an up error
// - pad not back up within five seconds after apply raises up error
// - up error energises fault relay and strobes the up relay
// - strobing stops when pad is up; error stays until reset or stop
// - apply not reaching down within three seconds raises down error
// - down relay follows the pad's down position
// - fault relay holds until reset or stop, even once the fault has gone
`timescale 1ns/1ps
`default_nettype none
module apc_ctrl #(
    parameter int TICK_CYC     = apc_pkg::TICK_CYCLES,
    parameter int UP_TMO_TICKS = apc_pkg::UP_TIMEOUT_TICKS,
    parameter int DN_TMO_TICKS = apc_pkg::DOWN_TIMEOUT_TICKS
) (
    // clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    // port pins and panel button
    input  wire apc_pkg::apc_pins_s  pins_i,
    // printer handshakes
    input  wire apc_pkg::apc_ptr_s   ptr_i,
    // mechanism commands
    output var apc_pkg::apc_mech_s   mech_o,
    // relays
    output var apc_pkg::apc_relay_s  relay_o
);
    import apc_pkg::*;

    localparam logic [TMR_W-1:0] UP_LAST = TMR_W'(UP_TMO_TICKS - 1);
    localparam logic [TMR_W-1:0] DN_LAST = TMR_W'(DN_TMO_TICKS - 1);
    localparam logic [DEB_W-1:0] CMD_DEB = DEB_W'(CMD_DEBOUNCE_MS);
    localparam logic [DEB_W-1:0] SNS_DEB = DEB_W'(SENSOR_DEBOUNCE_MS);

    logic      tick;
    logic      strobe;
    logic      start_raw;
    logic      stop_raw;
    logic      start_pulse;
    logic      stop_pulse;
    logic      btn_pulse;
    logic      pad_up;
    logic      pad_down;
    logic      set_up;
    logic      set_dn;
    logic      clr;
    logic      err_any;
    apc_ctrl_s st_reg;
    apc_ctrl_s st_next;

    apc_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_o    (tick),
        .strobe_o  (strobe)
    );

    // differential pair: either line may carry the trigger
    assign start_raw = pins_i.start_p & ~pins_i.start_n;
    assign stop_raw  = pins_i.stop_p & ~pins_i.stop_n;

    apc_sync #(.DEB_TICKS (CMD_DEB)) u_start (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_i    (tick),
        .raw_i     (start_raw),
        .level_o   (),
        .rise_o    (start_pulse)
    );

    apc_sync #(.DEB_TICKS (CMD_DEB)) u_stop (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_i    (tick),
        .raw_i     (stop_raw),
        .level_o   (),
        .rise_o    (stop_pulse)
    );

    apc_sync #(.DEB_TICKS (CMD_DEB)) u_btn (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_i    (tick),
        .raw_i     (pins_i.reset_btn),
        .level_o   (),
        .rise_o    (btn_pulse)
    );

    // sensors get a short filter only so relays track the pad closely
    apc_sync #(.DEB_TICKS (SNS_DEB)) u_up (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_i    (tick),
        .raw_i     (pins_i.pad_up),
        .level_o   (pad_up),
        .rise_o    ()
    );

    apc_sync #(.DEB_TICKS (SNS_DEB)) u_down (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_i    (tick),
        .raw_i     (pins_i.pad_down),
        .level_o   (pad_down),
        .rise_o    ()
    );

    assign err_any = st_reg.up_err | st_reg.dn_err;
    assign clr     = stop_pulse | btn_pulse;

    // error detection, independent of the stop path so a set is never lost
    always_comb begin
        set_up = 1'b0;
        set_dn = 1'b0;
        if (st_reg.state == ST_FEED && !pad_up) begin
            set_up = 1'b1;
        end
        if (st_reg.state == ST_RETURN && !pad_up && tick
            && st_reg.tmr == UP_LAST) begin
            set_up = 1'b1;
        end
        if (st_reg.state == ST_APPLY && !pad_down && tick
            && st_reg.tmr == DN_LAST) begin
            set_dn = 1'b1;
        end
    end

    always_comb begin
        st_next = st_reg;
        // latched until cleared; a set in the clearing cycle wins
        st_next.up_err = (st_reg.up_err & ~clr) | set_up;
        st_next.dn_err = (st_reg.dn_err & ~clr) | set_dn;
        unique case (st_reg.state)
            ST_IDLE: begin
                // a start with no job or a latched fault is simply dropped
                if (start_pulse && ptr_i.job_pending && !err_any) begin
                    st_next.state      = ST_PRINT;
                    st_next.mech.print = 1'b1;
                end
            end
            ST_PRINT: begin
                if (ptr_i.print_done) begin
                    st_next.state      = ST_FEED;
                    st_next.mech.print = 1'b0;
                    st_next.mech.feed  = 1'b1;
                end
            end
            ST_FEED: begin
                if (set_up) begin
                    st_next.state     = ST_RETURN;
                    st_next.mech.feed = 1'b0;
                    st_next.tmr       = '0;
                end else if (ptr_i.feed_done) begin
                    st_next.state      = ST_APPLY;
                    st_next.mech.feed  = 1'b0;
                    st_next.mech.apply = 1'b1;
                    st_next.tmr        = '0;
                end
            end
            ST_APPLY: begin
                if (pad_down || set_dn) begin
                    st_next.state      = ST_RETURN;
                    st_next.mech.apply = 1'b0;
                    st_next.tmr        = '0;
                end else if (tick) begin
                    st_next.tmr = st_reg.tmr + 13'h0001;
                end
            end
            ST_RETURN: begin
                if (pad_up || set_up) begin
                    st_next.state = ST_IDLE;
                end else if (tick) begin
                    st_next.tmr = st_reg.tmr + 13'h0001;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
                st_next.mech  = '0;
            end
        endcase
        // stop overrides every state; return supervision re-raises
        // an up error if the pad still cannot get home
        if (stop_pulse) begin
            st_next.state = ST_RETURN;
            st_next.mech  = '0;
            st_next.tmr   = '0;
        end
        // relays: strobe the up relay while a fault is latched and the pad
        // is away from home
        if ((st_next.up_err | st_next.dn_err) && !pad_up) begin
            st_next.relay.up = strobe;
        end else begin
            st_next.relay.up = pad_up;
        end
        st_next.relay.down            = pad_down;
        st_next.relay.fault_relay_out = st_next.up_err | st_next.dn_err;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg.state                 <= ST_IDLE;
            st_reg.tmr                   <= '0;
            st_reg.up_err                <= FAULT_RESET;
            st_reg.dn_err                <= FAULT_RESET;
            st_reg.mech                  <= {3{MECH_RESET}};
            st_reg.relay                 <= {3{RELAY_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign mech_o  = st_reg.mech;
    assign relay_o = st_reg.relay;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    start_accept_a: assert property (
        st_reg.state == ST_IDLE && start_pulse && ptr_i.job_pending
        && !err_any && !stop_pulse
        |=> st_reg.state == ST_PRINT && mech_o.print)
        else $error("start with job did not begin printing");

    start_drop_a: assert property (
        st_reg.state == ST_IDLE && start_pulse && !ptr_i.job_pending
        && !stop_pulse
        |=> st_reg.state == ST_IDLE && mech_o == '0)
        else $error("start without job was not dropped");

    stop_abort_a: assert property (
        stop_pulse |=> st_reg.state == ST_RETURN && mech_o == '0)
        else $error("stop did not abort and retract");

    stop_clear_a: assert property (
        stop_pulse && !set_up && !set_dn |=> !err_any ##1
        !relay_o.fault_relay_out || $past(set_up) || $past(set_dn))
        else $error("stop did not clear latched error");

    up_follow_a: assert property (
        !st_next.up_err && !st_next.dn_err |=> relay_o.up == $past(pad_up))
        else $error("up relay not following pad position");

    feed_error_a: assert property (
        st_reg.state == ST_FEED && !pad_up |=> st_reg.up_err
        && st_reg.state != ST_APPLY)
        else $error("pad left up during feed without error");

    return_tmo_a: assert property (
        st_reg.state == ST_RETURN && !pad_up && tick
        && st_reg.tmr == UP_LAST |=> st_reg.up_err && relay_o.fault_relay_out)
        else $error("missing up timeout error");

    strobe_out_a: assert property (
        st_next.up_err && !pad_up |=> relay_o.up == $past(strobe)
        && relay_o.fault_relay_out)
        else $error("up error not strobing up relay");

    fault_hold_a: assert property (
        err_any && !clr |=> err_any)
        else $error("fault dropped without reset or stop");

    down_tmo_a: assert property (
        st_reg.state == ST_APPLY && !pad_down && tick
        && st_reg.tmr == DN_LAST |=> st_reg.dn_err && !mech_o.apply)
        else $error("missing down timeout error");

    down_follow_a: assert property (
        1'b1 |=> relay_o.down == $past(pad_down))
        else $error("down relay not following pad position");

endmodule : apc_ctrl
`default_nettype wire

// File: verification/apc_pad_model.sv
// pad mechanism and printer stand-in for the port control bench
// assumes mechanism commands are levels on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module apc_pad_model (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    // commands from the block
    input  wire apc_pkg::apc_mech_s mech_i,
    // fault injection from the bench
    input  wire logic               slow_i,
    input  wire logic               stuck_i,
    input  wire logic               no_down_i,
    // sensors and printer handshakes
    output logic                    pad_up_o,
    output logic                    pad_down_o,
    output logic                    print_done_o,
    output logic                    feed_done_o
);
    import apc_pkg::*;

    logic [4:0] pos_reg;
    logic [8:0] cnt_reg;
    logic [8:0] lim;

    // slow printer leaves room to act in mid-print or mid-feed
    assign lim = slow_i ? 9'h190 : 9'h008;

    // pad travel is 20 cycles; a jammed stroke stops one short
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pos_reg <= 5'h00;
            cnt_reg <= 9'h000;
        end else begin
            if (mech_i.apply && pos_reg < (no_down_i ? 5'h13 : 5'h14)) begin
                pos_reg <= pos_reg + 5'h01;
            end else if (!mech_i.apply && pos_reg != 5'h00) begin
                pos_reg <= pos_reg - 5'h01;
            end
            if ((mech_i.print || mech_i.feed) && cnt_reg != lim) begin
                cnt_reg <= cnt_reg + 9'h001;
            end else begin
                cnt_reg <= 9'h000;
            end
        end
    end

    assign pad_up_o     = (pos_reg == 5'h00) && !stuck_i;
    assign pad_down_o   = (pos_reg == 5'h14);
    assign print_done_o = mech_i.print && (cnt_reg == lim);
    assign feed_done_o  = mech_i.feed && (cnt_reg == lim);
endmodule : apc_pad_model
`default_nettype wire

// File: verification/apc_ctrl_tb.sv
// self-checking bench for the applicator port control
// assumes shortened tick and timeout parameters and the pad model
`timescale 1ns/1ps
`default_nettype none
module apc_ctrl_tb;
    import apc_pkg::*;

    logic       clk_sys_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic       sp = 1'b0, sn = 1'b0, tp = 1'b0, rb = 1'b0, job = 1'b0;
    logic       slow = 1'b0, stuck = 1'b0, nd = 1'b0;
    wire logic  pu, pd, pdn, fdn;
    apc_pins_s  pins;
    apc_ptr_s   ptr;
    apc_mech_s  mech;
    apc_relay_s relay;
    int         num_errors = 0;
    int         samples_checked = 0;
    int         n;

    always #4 clk_sys_i = ~clk_sys_i;
    assign pins = {sp, sn, tp, 1'b0, pu, pd, rb};
    assign ptr  = {job, pdn, fdn};

    apc_ctrl #(.TICK_CYC(10), .UP_TMO_TICKS(50), .DN_TMO_TICKS(30)) dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins_i(pins),
        .ptr_i(ptr), .mech_o(mech), .relay_o(relay));

    apc_pad_model pad (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .mech_i(mech),
        .slow_i(slow), .stuck_i(stuck), .no_down_i(nd), .pad_up_o(pu),
        .pad_down_o(pd), .print_done_o(pdn), .feed_done_o(fdn));

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int v);
        samples_checked++;
        if (v < lo || v > hi) begin
            num_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask : chk_rng

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask : cyc

    function automatic logic sig(input int w);
        case (w)
            0: return mech.print;
            1: return mech.feed;
            2: return mech.apply;
            3: return relay.fault_relay_out;
            4: return relay.down;
            default: return relay.up;
        endcase
    endfunction : sig

    // bounded wait; cycles taken are left in n
    task automatic wt(input int w, input logic v, input int mx);
        n = 0;
        while (sig(w) !== v && n < mx) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk($sformatf("output %0d", w), v, sig(w));
    endtask : wt

    task automatic toggles(input int k, output int t);
        logic last;
        t = 0;
        last = relay.up;
        repeat (k) begin
            @(negedge clk_sys_i);
            if (relay.up !== last) t++;
            last = relay.up;
        end
    endtask : toggles

    // neg selects the minus line as the trigger, plus held high
    task automatic start(input logic neg, input logic on);
        sp = neg | on;
        sn = neg & ~on;
    endtask : start

    // held well past the 10 tick command filter
    task automatic press(input logic btn);
        if (btn) rb = 1'b1;
        else tp = 1'b1;
        cyc(150);
        rb = 1'b0;
        tp = 1'b0;
        cyc(150);
    endtask : press

    task automatic t_reset();
        chk("mech idle", 1'b0, |mech);
        chk("fault idle", 1'b0, relay.fault_relay_out);
        cyc(50);
        chk("up relay", 1'b1, relay.up);
        chk("down relay", 1'b0, relay.down);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cycle(input logic neg);
        job = 1'b1;
        start(neg, 1'b0);
        cyc(150);
        start(neg, 1'b1);
        wt(0, 1'b1, 300);
        wt(1, 1'b1, 20);
        wt(2, 1'b1, 20);
        wt(4, 1'b1, 80);
        chk("up relay away", 1'b0, relay.up);
        wt(4, 1'b0, 40);
        wt(5, 1'b1, 80);
        cyc(300);
        chk("held start", 1'b0, mech.print);
        start(neg, 1'b0);
        cyc(150);
        $display("test cycle done");
    endtask : t_cycle

    task automatic t_nojob();
        job = 1'b0;
        start(1'b0, 1'b1);
        cyc(200);
        chk("no job", 1'b0, mech.print);
        job = 1'b1;
        cyc(200);
        chk("not queued", 1'b0, mech.print);
        start(1'b0, 1'b0);
        cyc(150);
        $display("test no job done");
    endtask : t_nojob

    task automatic t_stop();
        slow = 1'b1;
        start(1'b0, 1'b1);
        wt(1, 1'b1, 800);
        tp = 1'b1;
        wt(1, 1'b0, 200);
        cyc(450);
        chk("no apply", 1'b0, mech.apply);
        chk("pad home", 1'b1, relay.up);
        tp = 1'b0;
        start(1'b0, 1'b0);
        slow = 1'b0;
        cyc(150);
        $display("test stop done");
    endtask : t_stop

    task automatic t_feed_err();
        int t;
        slow = 1'b1;
        start(1'b0, 1'b1);
        wt(1, 1'b1, 800);
        stuck = 1'b1;
        wt(3, 1'b1, 100);
        cyc(2);
        chk("feed dropped", 1'b0, mech.feed);
        toggles(6000, t);
        chk_rng("strobe", 2, 3, t);
        stuck = 1'b0;
        start(1'b0, 1'b0);
        cyc(50);
        toggles(3000, t);
        chk_rng("steady up", 0, 0, t);
        chk("up relay", 1'b1, relay.up);
        chk("latched", 1'b1, relay.fault_relay_out);
        press(1'b1);
        chk("cleared", 1'b0, relay.fault_relay_out);
        slow = 1'b0;
        $display("test feed fault done");
    endtask : t_feed_err

    task automatic t_up_tmo();
        start(1'b0, 1'b1);
        wt(4, 1'b1, 400);
        stuck = 1'b1;
        wt(2, 1'b0, 20);
        wt(3, 1'b1, 700);
        chk_rng("up timeout", 470, 520, n);
        start(1'b0, 1'b0);
        press(1'b0);
        chk("stop clears", 1'b0, relay.fault_relay_out);
        wt(3, 1'b1, 700);
        stuck = 1'b0;
        press(1'b0);
        cyc(700);
        chk("stays clear", 1'b0, relay.fault_relay_out);
        $display("test up timeout done");
    endtask : t_up_tmo

    task automatic t_dn_err();
        nd = 1'b1;
        start(1'b0, 1'b1);
        wt(2, 1'b1, 400);
        wt(3, 1'b1, 400);
        chk_rng("down timeout", 280, 315, n);
        cyc(2);
        chk("apply dropped", 1'b0, mech.apply);
        chk("not down", 1'b0, relay.down);
        nd = 1'b0;
        start(1'b0, 1'b0);
        cyc(100);
        chk("held", 1'b1, relay.fault_relay_out);
        press(1'b1);
        chk("cleared", 1'b0, relay.fault_relay_out);
        $display("test down timeout done");
    endtask : t_dn_err

    initial begin
        cyc(6);
        reset_i = 1'b0;
        cyc(2);
        t_reset();
        t_cycle(1'b0);
        t_cycle(1'b1);
        t_nojob();
        t_stop();
        t_feed_err();
        t_up_tmo();
        t_dn_err();
        final_report();
    end

    // whole run is near 17k cycles; 50k cycles means a hang
    initial begin
        #400_000;
        num_errors++;
        final_report();
    end
endmodule : apc_ctrl_tb
`default_nettype wire
